// ### rtl/flash_lock_regs.svh
`ifndef FLASH_LOCK_REGS_SVH
`define FLASH_LOCK_REGS_SVH
// Command opcodes
`define OPC_READ_LOCK 8'h3d
`define OPC_BLOCK_LOCK 8'h36
`define OPC_BLOCK_UNLOCK 8'h39
`define OPC_GLOBAL_LOCK 8'h7e
`define OPC_GLOBAL_UNLOCK 8'h98
`define OPC_RESET_ENABLE 8'h66
`define OPC_RESET_DEVICE 8'h99
// Bit counts of a frame
`define OPC_BITS 6'h08
`define ADDR_END_BITS 6'h20
// Lock bit index field of the address
`define LOCK_IDX_MSB 22
`define LOCK_IDX_LSB 16
`define SECT_IDX_LSB 12
// Lock bits after reset: all protected
`define LOCK_RESET_VAL {128{1'b1}}
// Reset recovery time
`define T_RST_US 30
`define SYS_CLK_MHZ 100
`define T_RST_CYC (`T_RST_US * `SYS_CLK_MHZ)
`endif

// ### rtl/flash_lock_pkg.sv
package flash_lock_pkg;
  // Protection configuration bits
  typedef struct packed {
    logic lock_mode_select;
    logic protect_complement;
    logic sector_granularity;
    logic top_bottom_select;
    logic [2:0] protect_range_bits;
  } prot_cfg_t;
  // Frame engine states, Gray along the path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DATA = 2'b11
  } state_t;
endpackage

// ### rtl/flash_lock_ctrl.sv
`timescale 1ns/1ns
`include "flash_lock_regs.svh"
// Operation
// RQ1: Individual locks apply only when mode bit 1
// RQ2: Mode 0 uses range protection bits only
// RQ3: Lock bits volatile, all ones after reset
// RQ4: Host sends read-lock opcode plus address
// RQ5: Lock byte shifted out falling edges MSB
// RQ6: Returned LSB 1 locked, 0 unlocked
// RQ7: Global lock sets every lock bit
// RQ8: Global unlock clears every lock bit
// RQ9: Global lock needs write enable latch set
// RQ10: Global unlock needs write enable latch set
// RQ11: Reset aborts work, restores volatile defaults
// RQ12: Reset only by enable then reset opcodes
// RQ13: Other command after enable cancels arming
// RQ14: Reset recovery lasts about thirty microseconds
// RQ15: Commands ignored during reset recovery
// RQ16: Host checks busy and suspend first
// RQ17: Block lock with address sets bit
// RQ18: Block unlock with address clears bit
// RQ19: Lock commands ignored without write enable
// RQ20: Address maps to lock bit by granularity; code always uses address bits 22:16, one bit per 64 KB block
module flash_lock_ctrl (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n_o,
  // Mode and status from the rest of the device
  input wire logic four_line_command_mode_i,
  input wire logic write_enable_latch_i,
  input wire flash_lock_pkg::prot_cfg_t prot_cfg_i,
  // Array write-protection query
  input wire logic [23:0] chk_addr_i,
  output logic chk_protected_o,
  // Soft reset outputs
  output logic soft_reset_o,
  output logic busy_o
);
  // Synchronisers: stage 1 feeds only stage 2
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic [3:0] io_s1_r, io_s2_r;
  // Frame engine state
  flash_lock_pkg::state_t st_r, st_nxt;
  logic [31:0] sh_r, sh_nxt; // Opcode and address shifter
  logic [5:0] cnt_r, cnt_nxt; // Bits received, saturating
  logic [7:0] op_r, op_nxt; // Opcode of this frame
  logic [7:0] out_r, out_nxt; // Lock byte being sent
  logic [3:0] io_r, io_nxt;
  logic [3:0] oe_n_r, oe_n_nxt;
  // Lock and reset state
  logic [127:0] locks_r, locks_nxt;
  logic arm_r, arm_nxt; // Reset-enable seen
  logic [11:0] rcnt_r, rcnt_nxt; // Recovery countdown
  logic srst_r, srst_nxt;
  logic prot_r, prot_nxt;
  // Decoded helpers
  logic sclk_rise, sclk_fall, cs_rise, frame_end, four_line_command_mode;
  logic [5:0] cnt_inc;
  logic [6:0] blk_idx;
  // Pin synchronisers, two flops before any logic
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      // Deselected, clock low: matches idle pins, no false edge
      {cs_s3_r, cs_s2_r, cs_s1_r} <= 3'h7;
      {sclk_s3_r, sclk_s2_r, sclk_s1_r} <= 3'h0;
      {io_s2_r, io_s1_r} <= 8'h00;
    end else begin
      {cs_s3_r, cs_s2_r, cs_s1_r} <= {cs_s2_r, cs_s1_r, cs_n_i};
      {sclk_s3_r, sclk_s2_r, sclk_s1_r} <= {sclk_s2_r, sclk_s1_r, sclk_i};
      {io_s2_r, io_s1_r} <= {io_s1_r, io_i};
    end
  end

  // Edges seen only on the synchronised copies
  assign sclk_rise = sclk_s2_r & ~sclk_s3_r;
  assign sclk_fall = ~sclk_s2_r & sclk_s3_r;
  assign cs_rise = cs_s2_r & ~cs_s3_r;
  assign frame_end = cs_rise && (st_r != flash_lock_pkg::ST_IDLE);
  assign four_line_command_mode = four_line_command_mode_i;
  assign cnt_inc = four_line_command_mode ? 6'h04 : 6'h01;
  // One lock bit per 64 KB block of the 8 MB array
  assign blk_idx = sh_r[`LOCK_IDX_MSB:`LOCK_IDX_LSB]; // RQ20

  // Range protection from the status bits alone
  function automatic logic range_prot(
    input flash_lock_pkg::prot_cfg_t c,
    input logic [23:0] a
  );
    logic [10:0] unit;
    logic [11:0] n;
    logic [11:0] total;
    logic hit;
    unit = c.sector_granularity ? a[22:12] : {4'h0, a[22:16]};
    total = c.sector_granularity ? 12'h800 : 12'h080;
    n = 12'h001 << (c.protect_range_bits - 3'h1);
    if (c.protect_range_bits == 3'h0) begin
      hit = 1'b0;
    end else if (c.protect_range_bits == 3'h7) begin
      hit = 1'b1;
    end else if (c.top_bottom_select) begin
      hit = {1'b0, unit} < n;
    end else begin
      hit = {1'b0, unit} >= (total - n);
    end
    return hit ^ c.protect_complement;
  endfunction

  // Frame engine: opcode, address and lock byte out
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    out_nxt = out_r;
    io_nxt = io_r;
    oe_n_nxt = oe_n_r;
    case (st_r)
      flash_lock_pkg::ST_IDLE: begin
        // Recovery keeps the engine idle; a frame still selected when it ends is shifted from then on
        if (!cs_s2_r && !busy_o) begin // RQ15
          st_nxt = flash_lock_pkg::ST_SHIFT;
          cnt_nxt = 6'h00;
        end
      end
      flash_lock_pkg::ST_SHIFT: begin
        // Sample on rising clock edges
        if (sclk_rise) begin
          sh_nxt = four_line_command_mode ? {sh_r[27:0], io_s2_r} : {sh_r[30:0], io_s2_r[0]};
          if (cnt_r < `ADDR_END_BITS) begin
            cnt_nxt = cnt_r + cnt_inc;
          end
          if (cnt_r + cnt_inc == `OPC_BITS) begin
            op_nxt = sh_nxt[7:0];
          end
          // Address complete: load the lock byte
          if (cnt_r + cnt_inc == `ADDR_END_BITS
              && op_r == `OPC_READ_LOCK) begin
            st_nxt = flash_lock_pkg::ST_DATA;
            out_nxt = {7'h00,
              locks_r[sh_nxt[`LOCK_IDX_MSB:`LOCK_IDX_LSB]]}; // RQ6
          end
        end
      end
      flash_lock_pkg::ST_DATA: begin
        // Drive on falling edges, MSB first, byte repeats
        if (sclk_fall) begin // RQ5
          if (four_line_command_mode) begin
            io_nxt = out_r[7:4];
            oe_n_nxt = 4'h0;
            out_nxt = {out_r[3:0], out_r[7:4]};
          end else begin
            io_nxt = {2'b00, out_r[7], 1'b0};
            oe_n_nxt = 4'hd;
            out_nxt = {out_r[6:0], out_r[7]};
          end
        end
      end
      default: begin
        st_nxt = flash_lock_pkg::ST_IDLE;
      end
    endcase
    // Deselect ends every frame and releases the lines
    if (cs_s2_r) begin
      st_nxt = flash_lock_pkg::ST_IDLE;
      oe_n_nxt = 4'hf;
    end
  end
  // Frame engine registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= flash_lock_pkg::ST_IDLE;
      sh_r <= 32'h0;
      cnt_r <= 6'h00;
      {op_r, out_r} <= 16'h0000;
      {io_r, oe_n_r} <= 8'h0f;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      {op_r, out_r} <= {op_nxt, out_nxt};
      {io_r, oe_n_r} <= {io_nxt, oe_n_nxt};
    end
  end

  // Commands execute at deselect, so a cut frame can only clear arm_r
  always_comb begin
    locks_nxt = locks_r;
    arm_nxt = arm_r;
    rcnt_nxt = (rcnt_r != 12'h000) ? rcnt_r - 12'h001 : 12'h000;
    srst_nxt = 1'b0;
    if (frame_end && cnt_r >= `OPC_BITS) begin
      // Any frame of at least eight bits but reset-enable disarms
      arm_nxt = (op_r == `OPC_RESET_ENABLE); // RQ13
      case (op_r)
        `OPC_GLOBAL_LOCK: begin
          if (write_enable_latch_i && cnt_r == `OPC_BITS) begin // RQ9
            locks_nxt = `LOCK_RESET_VAL; // RQ7
          end
        end
        `OPC_GLOBAL_UNLOCK: begin
          if (write_enable_latch_i && cnt_r == `OPC_BITS) begin // RQ10
            locks_nxt = '0; // RQ8
          end
        end
        `OPC_BLOCK_LOCK: begin
          // Without write enable the bit stays put
          if (write_enable_latch_i && cnt_r == `ADDR_END_BITS) begin // RQ19
            locks_nxt[blk_idx] = 1'b1; // RQ17
          end
        end
        `OPC_BLOCK_UNLOCK: begin
          if (write_enable_latch_i && cnt_r == `ADDR_END_BITS) begin // RQ19
            locks_nxt[blk_idx] = 1'b0; // RQ18
          end
        end
        `OPC_RESET_DEVICE: begin
          // Only straight after an enable frame, any mode
          if (arm_r && cnt_r == `OPC_BITS) begin // RQ12
            srst_nxt = 1'b1; // RQ11
            locks_nxt = `LOCK_RESET_VAL; // RQ3
            rcnt_nxt = 12'(`T_RST_CYC - 1); // RQ14
          end
        end
        default: locks_nxt = locks_r;
      endcase
    end
  end

  // Protection verdict for the queried address
  always_comb begin
    if (prot_cfg_i.lock_mode_select) begin
      prot_nxt = locks_r[chk_addr_i[`LOCK_IDX_MSB:`LOCK_IDX_LSB]]; // RQ1
    end else begin
      prot_nxt = range_prot(prot_cfg_i, chk_addr_i); // RQ2
    end
  end
  // Lock and reset registers; locks start protected
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      locks_r <= `LOCK_RESET_VAL; // RQ3
      {arm_r, srst_r} <= 2'h0;
      rcnt_r <= 12'h000;
      prot_r <= 1'b1;
    end else begin
      locks_r <= locks_nxt;
      {arm_r, srst_r} <= {arm_nxt, srst_nxt};
      rcnt_r <= rcnt_nxt;
      prot_r <= prot_nxt;
    end
  end

  assign io_o = io_r;
  assign io_oe_n_o = oe_n_r;
  assign chk_protected_o = prot_r;
  assign soft_reset_o = srst_r;
  assign busy_o = (rcnt_r != 12'h000);
  // Checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_enter_data;
    st_r == flash_lock_pkg::ST_SHIFT ##1 st_r == flash_lock_pkg::ST_DATA;
  endsequence
  sequence s_reset_frame;
    frame_end && op_r == `OPC_RESET_DEVICE && arm_r && cnt_r == `OPC_BITS;
  endsequence

  property p_mode_lock;
    prot_cfg_i.lock_mode_select && &locks_r |=> chk_protected_o;
  endproperty
  a_mode_lock: assert property (p_mode_lock) // RQ1
    else $error("locked block not protected");
  property p_mode_range;
    !prot_cfg_i.lock_mode_select && prot_cfg_i.protect_range_bits == 3'h0
      && !prot_cfg_i.protect_complement |=> !chk_protected_o;
  endproperty
  a_mode_range: assert property (p_mode_range) // RQ2
    else $error("range mode ignored");
  property p_reset_locks;
    s_reset_frame |=> &locks_r && soft_reset_o ##1 !soft_reset_o;
  endproperty
  a_reset_locks: assert property (p_reset_locks) // RQ3
    else $error("reset did not relock");
  property p_lock_byte;
    s_enter_data |-> out_r[7:1] == 7'h00 && out_r[0] == locks_r[blk_idx];
  endproperty
  a_lock_byte: assert property (p_lock_byte) // RQ6
    else $error("wrong lock byte");
  property p_spi_out;
    st_r == flash_lock_pkg::ST_DATA && sclk_fall && !four_line_command_mode && !cs_s2_r
      |=> io_o[1] == $past(out_r[7]) && io_oe_n_o == 4'hd;
  endproperty
  a_spi_out: assert property (p_spi_out) // RQ5
    else $error("serial output wrong");
  property p_glock;
    frame_end && op_r == `OPC_GLOBAL_LOCK && cnt_r == `OPC_BITS
      && write_enable_latch_i |=> &locks_r;
  endproperty
  a_glock: assert property (p_glock) // RQ7
    else $error("global lock failed");
  property p_gunlock;
    frame_end && op_r == `OPC_GLOBAL_UNLOCK && cnt_r == `OPC_BITS
      && write_enable_latch_i |=> locks_r == '0;
  endproperty
  a_gunlock: assert property (p_gunlock) // RQ8
    else $error("global unlock failed");
  property p_no_wel;
    frame_end && !write_enable_latch_i && op_r != `OPC_RESET_DEVICE
      |=> $stable(locks_r);
  endproperty
  a_no_wel: assert property (p_no_wel) // RQ19
    else $error("locks changed without write enable");
  property p_disarm;
    frame_end && cnt_r >= `OPC_BITS && op_r != `OPC_RESET_ENABLE |=> !arm_r;
  endproperty
  a_disarm: assert property (p_disarm) // RQ13
    else $error("reset enable not cancelled");
  property p_rst_len;
    s_reset_frame |=> rcnt_r == 12'(`T_RST_CYC - 1) && busy_o;
  endproperty
  a_rst_len: assert property (p_rst_len) // RQ14
    else $error("recovery time wrong");
  property p_ignore;
    busy_o && st_r == flash_lock_pkg::ST_IDLE |=> $stable(st_r);
  endproperty
  a_ignore: assert property (p_ignore) // RQ15
    else $error("command taken during recovery");
  property p_only_seq;
    $rose(soft_reset_o) |-> $past(arm_r) && $past(op_r) == `OPC_RESET_DEVICE;
  endproperty
  a_only_seq: assert property (p_only_seq) // RQ12
    else $error("reset without enable");
endmodule

// ### verif/host_model.sv
`timescale 1ns/1ns
// Host flash controller: bits change while sclk is low
module host_model (
  // Alignment clock
  input wire logic sys_clk_i,
  // Pins toward the device
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o,
  // Pins from the device
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_oe_n_i
);
  // Idle: deselected, clock parked low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'ha;
  end

  // One frame: nb command bits out, then nrd read bits in
  task automatic frame(input logic [31:0] word, input int nb,
    input int nrd, input logic q, output logic [7:0] rd,
    output logic [3:0] oe);
    int w;
    w = q ? 4 : 1;
    rd = 8'h00;
    oe = 4'hf;
    @(posedge sys_clk_i);
    #1 cs_n_o = 1'b0;
    for (int i = 0; i < nb; i += w) begin
      // Unused lines toggle so a stale level cannot pass
      io_o = q ? word[31 - i -: 4] : {~io_o[3:1], word[31 - i]};
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    for (int j = 0; j < nrd; j += w) begin
      // Released lines do not keep the last value
      io_o = ~io_o;
      // Sample late in the low phase, data launched on the fall
      #80 rd = q ? {rd[3:0], dev_io_i} : {rd[6:0], dev_io_i[1]};
      oe = dev_oe_n_i;
      sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
    end
    #80 cs_n_o = 1'b1;
    io_o = ~io_o;
    // Deselect gap covers the synchroniser and execute delay
    #240;
  endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ns
`include "flash_lock_regs.svh"
module tb;
  // Stimulus and observed signals
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic quad = 1'b0;
  logic write_enable_latch = 1'b0;
  flash_lock_pkg::prot_cfg_t cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h0};
  logic [23:0] chk_addr = 24'h000000;
  logic cs_n, sclk, chk_prot, srst, busy;
  logic [3:0] hio, dio, doe, oe;
  logic [7:0] rd;
  int failures = 0;
  int comparisons = 0;
  int srst_cnt = 0;
  int busy_cnt = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  // Reset pulses and busy cycles are counted, not sampled once
  always @(posedge sys_clk_i) begin
    if (srst === 1'b1) srst_cnt++;
    if (busy === 1'b1) busy_cnt++;
  end

  flash_lock_ctrl dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .cs_n_i(cs_n), .sclk_i(sclk), .io_i(hio), .io_o(dio),
    .io_oe_n_o(doe), .four_line_command_mode_i(quad),
    .write_enable_latch_i(write_enable_latch), .prot_cfg_i(cfg),
    .chk_addr_i(chk_addr), .chk_protected_o(chk_prot),
    .soft_reset_o(srst), .busy_o(busy));

  host_model host_u (.sys_clk_i(sys_clk_i), .cs_n_o(cs_n),
    .sclk_o(sclk), .io_o(hio), .dev_io_i(dio), .dev_oe_n_i(doe));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Command frame without read phase
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
    input int nb);
    host_u.frame({op, a}, nb, 0, quad, rd, oe);
  endtask

  // Lock readback; also judges which lines the device drove
  task automatic rdlock(input logic [23:0] a);
    host_u.frame({`OPC_READ_LOCK, a}, 32, 8, quad, rd, oe);
    check({4'h0, oe}, quad ? 8'h00 : 8'h0d);
  endtask

  // Array protection query, one cycle latency plus margin
  task automatic chk(input logic [23:0] a, input logic exp);
    @(posedge sys_clk_i);
    #1 chk_addr = a;
    repeat (2) @(posedge sys_clk_i);
    #1 check({7'h00, chk_prot}, {7'h00, exp});
  endtask

  task automatic t_reset_state();
    for (int i = 0; i < 2; i++) begin
      quad = i[0];
      rdlock(24'h050000);
      check(rd, 8'h01);
    end
    quad = 1'b0;
    chk(24'h050000, 1'b1);
  endtask

  task automatic t_wel_gate();
    cmd(`OPC_GLOBAL_UNLOCK, 24'h0, 8);
    cmd(`OPC_BLOCK_UNLOCK, 24'h050000, 32);
    rdlock(24'h050000);
    check(rd, 8'h01);
    write_enable_latch = 1'b1;
    cmd(`OPC_GLOBAL_UNLOCK, 24'h0, 8);
    rdlock(24'h7f0000);
    check(rd, 8'h00);
    chk(24'h7f0000, 1'b0);
  endtask

  // Four-line mode for block commands
  task automatic t_block();
    quad = 1'b1;
    cmd(`OPC_BLOCK_LOCK, 24'h123456, 32);
    rdlock(24'h12ffff);
    check(rd, 8'h01);
    rdlock(24'h130000);
    check(rd, 8'h00);
    chk(24'h120abc, 1'b1);
    cmd(`OPC_BLOCK_UNLOCK, 24'h12f000, 32);
    rdlock(24'h123456);
    check(rd, 8'h00);
    quad = 1'b0;
  endtask

  task automatic t_global_lock();
    write_enable_latch = 1'b0;
    cmd(`OPC_GLOBAL_LOCK, 24'h0, 8);
    rdlock(24'h200000);
    check(rd, 8'h00);
    write_enable_latch = 1'b1;
    cmd(`OPC_GLOBAL_LOCK, 24'h0, 8);
    rdlock(24'h200000);
    check(rd, 8'h01);
  endtask

  // Locks are all set here, so range bits alone must decide
  task automatic t_range();
    cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 3'h0};
    chk(24'h200000, 1'b0);
    cfg.protect_range_bits = 3'h7;
    chk(24'h200000, 1'b1);
    cfg = '{1'b0, 1'b1, 1'b0, 1'b0, 3'h0};
    chk(24'h200000, 1'b1);
    cfg.lock_mode_select = 1'b1;
  endtask

  task automatic t_soft_reset();
    int n;
    cmd(`OPC_GLOBAL_UNLOCK, 24'h0, 8);
    cmd(`OPC_RESET_ENABLE, 24'h0, 8);
    rdlock(24'h000000);
    cmd(`OPC_RESET_DEVICE, 24'h0, 8);
    check(srst_cnt[7:0], 8'h00);
    check(rd, 8'h00);
    check({7'h00, busy}, 8'h00);
    quad = 1'b1;
    cmd(`OPC_RESET_ENABLE, 24'h0, 8);
    busy_cnt = 0;
    cmd(`OPC_RESET_DEVICE, 24'h0, 8);
    check(srst_cnt[7:0], 8'h01);
    cmd(`OPC_GLOBAL_UNLOCK, 24'h0, 8);
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge sys_clk_i);
      n++;
    end
    #1 check({7'h00, busy_cnt >= 2990 && busy_cnt <= 3010}, 8'h01);
    rdlock(24'h000000);
    check(rd, 8'h01);
    quad = 1'b0;
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    t_reset_state();
    t_wel_gate();
    t_block();
    t_global_lock();
    t_range();
    t_soft_reset();
    print_verdict();
  end

  // Watchdog well past the roughly 100 us the scenarios need
  initial begin
    #800000;
    failures++;
    print_verdict();
  end
endmodule
